// file: hw/mas_pkg.sv
// Package for the memory array sequencer: register map, field positions,
// address windows, sequencer states and the sequencer state record.
// Assumes a 32-bit APB register bus and a single core clock.
package mas_pkg;

    // Register byte offsets on the APB window.
    localparam logic [11:0] MAS_OFS_BANK_SEL = 12'h000;
    localparam logic [11:0] MAS_OFS_STATUS   = 12'h004;
    localparam logic [11:0] MAS_OFS_FAIL_CLR = 12'h008;

    // Field positions.
    localparam int MAS_BANK_BLOCK_BIT = 6;
    localparam int MAS_FAIL_CLR_BIT   = 0;
    localparam int MAS_ST_READ        = 0;
    localparam int MAS_ST_WORD        = 1;
    localparam int MAS_ST_RAM_SPACE   = 2;
    localparam int MAS_ST_EXTERNAL    = 3;
    localparam int MAS_ST_ODD_PERR    = 4;
    localparam int MAS_ST_EVEN_PERR   = 5;
    localparam int MAS_ST_HW_FAIL     = 6;
    localparam int MAS_ST_BUSY        = 7;
    localparam int MAS_ST_BANK        = 8;

    // Address windows of the external and constant spaces.
    localparam logic [15:0] MAS_RAM_EXT_LO = 16'hFF00;
    localparam logic [15:0] MAS_ROM_EXT_HI = 16'h3FFF;
    localparam logic [15:0] MAS_CONST_HI   = 16'h1FFF;

    // Timing chain length and the widest chain the state record can hold.
    localparam int MAS_CHAIN_LEN = 4;
    localparam int MAS_CHAIN_MAX = 8;

    // Sequencer states, one-hot.
    typedef enum logic [3:0] {
        MAS_IDLE    = 4'b0001,
        MAS_ACCESS  = 4'b0010,
        MAS_REFRESH = 4'b0100,
        MAS_EXTERN  = 4'b1000
    } mas_seq_t;

    // Complete state of the sequencer.
    typedef struct packed {
        mas_seq_t    seq;
        logic [7:0]  chain;
        logic        filling;
        logic [15:0] addr;
        logic        rd;
        logic        word;
        logic        ram_sp;
        logic        ext;
        logic        inc;
        logic        av_prev;
        logic        ind_prev;
        logic        ack_prev;
        logic        rfsh_prev;
        logic        pend_acc;
        logic        pend_rfsh;
        logic        accept;
        logic        xconf;
        logic        late;
        logic [7:0]  rcnt;
        logic        ope;
        logic        epe;
        logic        hwfail;
        logic        bank;
        logic [8:0]  odout;
        logic [8:0]  edout;
        logic [31:0] prdata;
    } mas_state_t;

    localparam mas_state_t MAS_STATE_RST = '{seq: MAS_IDLE, av_prev: 1'b1, ind_prev: 1'b1,
                                             ack_prev: 1'b1, default: '0};

endpackage : mas_pkg

// file: hw/mas_parity.sv
// Even parity generator and checker for one 8-bit bank byte.
// Assumes the stored ninth bit arrives together with its byte.
`timescale 1ns/1ns
module mas_parity (
    input  wire logic [7:0] data_in,
    input  wire logic       stored_in,
    output logic            gen_out,
    output logic            err_out
);

    // Even parity: the ninth bit makes the count of ones even.
    assign gen_out = ^data_in;
    assign err_out = ^{data_in, stored_in};

endmodule : mas_parity

// file: hw/mas_sequencer.sv
// Memory array sequencer: bank addressing, dynamic RAM strobes and refresh,
// parity, ROM selection, external space decode and an APB register window.
// Assumes requester inputs synchronous to CORE_CLK_IN and an external refresh timer.
`timescale 1ns/1ns
module mas_sequencer #(
    parameter int CHAIN_LEN = mas_pkg::MAS_CHAIN_LEN
) (
    input  wire logic        CORE_CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [11:0] PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic [31:0]      PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    input  wire logic        ADDR_VALID_N_IN,
    input  wire logic        INDIRECT_REQUEST_N_IN,
    input  wire logic        REFRESH_REQ_IN,
    input  wire logic [15:0] ADDR_IN,
    input  wire logic        REQ_READ_IN,
    input  wire logic        REQ_WORD_IN,
    input  wire logic        RAM_SPACE_SEL_IN,
    output logic             ADDR_ACCEPTED_N_OUT,
    output logic             DATA_CONFIRM_N_OUT,
    output logic             LATCHED_READ_OUT,
    output logic             LATCHED_WORD_OUT,
    output logic [14:0]      EVEN_BANK_WORD_ADDR_OUT,
    output logic [14:0]      ODD_BANK_WORD_ADDR_OUT,
    output logic             BYTE_LANE_SELECT_OUT,
    output logic             ADDR_INCREMENT_CTL_OUT,
    output logic             REFRESH_LATE_STROBE_OUT,
    output logic             REFRESH_EARLY_STROBE_N_OUT,
    output logic [6:0]       ODD_RAM_ADDR_OUT,
    output logic [6:0]       EVEN_RAM_ADDR_OUT,
    output logic [3:0]       RAS_N_OUT,
    output logic             COLUMN_STROBE_CLK_OUT,
    output logic             RAM_WRITE_OUT,
    output logic             ODD_ARRAY_EN_OUT,
    output logic             EVEN_ARRAY_EN_OUT,
    input  wire logic [7:0]  ODD_WDATA_IN,
    input  wire logic [7:0]  EVEN_WDATA_IN,
    input  wire logic [8:0]  ODD_RAM_DIN_IN,
    input  wire logic [8:0]  EVEN_RAM_DIN_IN,
    output logic [8:0]       ODD_RAM_DOUT_OUT,
    output logic [8:0]       EVEN_RAM_DOUT_OUT,
    output logic             ODD_PARITY_ERR_OUT,
    output logic             EVEN_PARITY_ERR_OUT,
    output logic             HW_FAIL_IRQ_N_OUT,
    output logic             ERROR_LED_OUT,
    output logic             ROM_STROBE_N_OUT,
    output logic             CONSTANT_ROM_SEL_N_OUT,
    output logic [3:0]       ODD_ROM_CS_N_OUT,
    output logic [3:0]       EVEN_ROM_CS_N_OUT,
    output logic             EXTRA_EPROM_EN_OUT,
    output logic             EXTERNAL_SELECT_N_OUT,
    output logic             EXT_REQUEST_N_OUT,
    input  wire logic        EXT_DATA_ACK_N_IN,
    output logic [15:0]      EXTERNAL_ADDR_OUT
);

    // The chain needs separate row, column and strobe stages.
    if (CHAIN_LEN < 3 || CHAIN_LEN > mas_pkg::MAS_CHAIN_MAX)
    begin : g_bad_chain
        $error("CHAIN_LEN must lie between 3 and 8");
    end

    localparam logic [7:0] CMASK = 8'((1 << CHAIN_LEN) - 1);

    mas_pkg::mas_state_t s_r;
    mas_pkg::mas_state_t s_nxt;

    logic        lane;
    logic [14:0] odd_word;
    logic [15:0] even_full;
    logic        inc_any;
    logic        is_rfsh;
    logic        is_acc;
    logic        run;
    logic        done_pt;
    logic        col_phase;
    logic        const_acc;
    logic        ram_acc;
    logic        rom_acc;
    logic        odd_en;
    logic        even_en;
    logic        acc_on;
    logic        rfsh_on;
    logic        av_fall;
    logic        ind_fall;
    logic        ack_fall;
    logic        rfsh_rise;
    logic        ext_hit;
    logic        odd_gen;
    logic        even_gen;
    logic        odd_err;
    logic        even_err;
    logic        fail_set;
    logic        rom_dec_en;
    logic [1:0]  odd_dev;
    logic [1:0]  even_dev;
    logic [31:0] status;
    logic        apb_wr;

    // Parity for the odd and even bytes; one instance per bank.
    mas_parity u_odd_par (
        .data_in   (s_r.rd ? ODD_RAM_DIN_IN[7:0] : ODD_WDATA_IN),
        .stored_in (ODD_RAM_DIN_IN[8]),
        .gen_out   (odd_gen),
        .err_out   (odd_err)
    );
    mas_parity u_even_par (
        .data_in   (s_r.rd ? EVEN_RAM_DIN_IN[7:0] : EVEN_WDATA_IN),
        .stored_in (EVEN_RAM_DIN_IN[8]),
        .gen_out   (even_gen),
        .err_out   (even_err)
    );

    // Address path: the adder feeds the even bank and the external bus.
    assign lane      = s_r.addr[0];
    assign odd_word  = s_r.addr[15:1];
    assign inc_any   = (s_r.word & lane & ~s_r.ext) | s_r.inc;
    assign even_full = s_r.addr + {15'h0000, inc_any};
    assign is_rfsh   = (s_r.seq == mas_pkg::MAS_REFRESH);
    assign is_acc    = (s_r.seq == mas_pkg::MAS_ACCESS);
    assign run       = is_rfsh | is_acc;
    assign done_pt   = run & ~s_r.filling & (s_r.chain == CMASK);
    assign col_phase = s_r.chain[1];

    // Space decode: the constant ROM shadows the lower RAM space.
    assign const_acc = s_r.ram_sp & ~s_r.ext & (s_r.addr <= mas_pkg::MAS_CONST_HI);
    assign ram_acc   = s_r.ram_sp & ~s_r.ext & ~const_acc;
    assign rom_acc   = ~s_r.ext & ~ram_acc;
    assign odd_en    = s_r.word | lane;
    assign even_en   = s_r.word | ~lane;
    assign acc_on    = is_acc & (s_r.chain != 8'h00);
    assign rfsh_on   = is_rfsh & (s_r.chain != 8'h00);

    // Request edges; inputs are synchronous so a single previous sample suffices.
    assign av_fall   = ~ADDR_VALID_N_IN & s_r.av_prev;
    assign ind_fall  = ~INDIRECT_REQUEST_N_IN & s_r.ind_prev;
    assign ack_fall  = ~EXT_DATA_ACK_N_IN & s_r.ack_prev;
    assign rfsh_rise = REFRESH_REQ_IN & ~s_r.rfsh_prev;
    assign ext_hit   = RAM_SPACE_SEL_IN ? (ADDR_IN >= mas_pkg::MAS_RAM_EXT_LO) :
                       ((ADDR_IN <= mas_pkg::MAS_ROM_EXT_HI) & ~s_r.bank);
    assign fail_set  = done_pt & is_acc & s_r.rd & ram_acc &
                       ((odd_err & odd_en) | (even_err & even_en));
    assign apb_wr    = PSEL_IN & PENABLE_IN & PWRITE_IN;

    // Status word as seen by software.
    always_comb
    begin
        status = 32'h00000000;
        status[mas_pkg::MAS_ST_READ]      = s_r.rd;
        status[mas_pkg::MAS_ST_WORD]      = s_r.word;
        status[mas_pkg::MAS_ST_RAM_SPACE] = s_r.ram_sp;
        status[mas_pkg::MAS_ST_EXTERNAL]  = s_r.ext;
        status[mas_pkg::MAS_ST_ODD_PERR]  = s_r.ope;
        status[mas_pkg::MAS_ST_EVEN_PERR] = s_r.epe;
        status[mas_pkg::MAS_ST_HW_FAIL]   = s_r.hwfail;
        status[mas_pkg::MAS_ST_BUSY]      = (s_r.seq != mas_pkg::MAS_IDLE);
        status[mas_pkg::MAS_ST_BANK]      = s_r.bank;
    end

    // Next state: sequencer, timing chain, parity latch and register writes.
    always_comb
    begin
        s_nxt           = s_r;
        s_nxt.accept    = 1'b0;
        s_nxt.xconf     = 1'b0;
        s_nxt.late      = 1'b0;
        s_nxt.av_prev   = ADDR_VALID_N_IN;
        s_nxt.ind_prev  = INDIRECT_REQUEST_N_IN;
        s_nxt.ack_prev  = EXT_DATA_ACK_N_IN;
        s_nxt.rfsh_prev = REFRESH_REQ_IN;
        s_nxt.odout     = {odd_gen, ODD_WDATA_IN};
        s_nxt.edout     = {even_gen, EVEN_WDATA_IN};
        case (s_r.seq)
            mas_pkg::MAS_IDLE:
            begin
                // Refresh goes first; an access waits so the two never overlap.
                if (s_r.pend_rfsh)
                begin
                    s_nxt.seq       = mas_pkg::MAS_REFRESH;
                    s_nxt.pend_rfsh = 1'b0;
                    s_nxt.chain     = 8'h00;
                    s_nxt.filling   = 1'b1;
                end
                else if (s_r.pend_acc)
                begin
                    s_nxt.pend_acc = 1'b0;
                    s_nxt.accept   = 1'b1;
                    s_nxt.addr     = ADDR_IN;
                    s_nxt.rd       = REQ_READ_IN;
                    s_nxt.word     = REQ_WORD_IN;
                    s_nxt.ram_sp   = RAM_SPACE_SEL_IN;
                    s_nxt.ext      = ext_hit;
                    s_nxt.inc      = 1'b0;
                    s_nxt.chain    = 8'h00;
                    s_nxt.filling  = 1'b1;
                    s_nxt.seq      = ext_hit ? mas_pkg::MAS_EXTERN : mas_pkg::MAS_ACCESS;
                end
            end
            mas_pkg::MAS_ACCESS, mas_pkg::MAS_REFRESH:
            begin
                // Fill with ones, then drain with zeros, one stage per clock.
                if (s_r.filling)
                begin
                    s_nxt.chain = {s_r.chain[6:0], 1'b1} & CMASK;
                    if (s_nxt.chain == CMASK)
                    begin
                        s_nxt.filling = 1'b0;
                    end
                end
                else if (s_r.chain == 8'h00)
                begin
                    s_nxt.seq  = mas_pkg::MAS_IDLE;
                    s_nxt.late = is_rfsh;
                end
                else
                begin
                    s_nxt.chain = {s_r.chain[6:0], 1'b0} & CMASK;
                end
            end
            mas_pkg::MAS_EXTERN:
            begin
                // A word needs one acknowledge per byte before the request drops.
                if (ack_fall)
                begin
                    if (s_r.word & ~s_r.inc)
                    begin
                        s_nxt.inc = 1'b1;
                    end
                    else
                    begin
                        s_nxt.inc   = 1'b0;
                        s_nxt.xconf = 1'b1;
                        s_nxt.seq   = mas_pkg::MAS_IDLE;
                    end
                end
            end
            default:
            begin
                s_nxt.seq = mas_pkg::MAS_IDLE;
            end
        endcase
        // Requests are set after the case so a new one is never lost to a start.
        if (av_fall | ind_fall)
        begin
            s_nxt.pend_acc = 1'b1;
        end
        if (rfsh_rise)
        begin
            s_nxt.pend_rfsh = 1'b1;
        end
        if (s_r.late)
        begin
            s_nxt.rcnt = s_r.rcnt + 8'h01;
        end
        // Parity is sampled when the column strobe has settled.
        if (done_pt & is_acc & s_r.rd & ram_acc)
        begin
            s_nxt.ope = odd_err & odd_en;
            s_nxt.epe = even_err & even_en;
        end
        // Register window; a failure arriving with its clear stays set.
        if (PSEL_IN & ~PENABLE_IN)
        begin
            s_nxt.prdata = (PADDR_IN == mas_pkg::MAS_OFS_STATUS) ? status : 32'h00000000;
        end
        if (apb_wr && PADDR_IN == mas_pkg::MAS_OFS_BANK_SEL)
        begin
            s_nxt.bank = PWDATA_IN[mas_pkg::MAS_BANK_BLOCK_BIT];
        end
        if (apb_wr && PADDR_IN == mas_pkg::MAS_OFS_FAIL_CLR && PWDATA_IN[mas_pkg::MAS_FAIL_CLR_BIT])
        begin
            s_nxt.hwfail = 1'b0;
        end
        if (fail_set)
        begin
            s_nxt.hwfail = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            s_r <= mas_pkg::MAS_STATE_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // APB answers with no wait states; unmapped offsets raise an error.
    assign PRDATA_OUT  = s_r.prdata;
    assign PREADY_OUT  = 1'b1;
    assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & (PADDR_IN != mas_pkg::MAS_OFS_BANK_SEL) &
                         (PADDR_IN != mas_pkg::MAS_OFS_STATUS) &
                         (PADDR_IN != mas_pkg::MAS_OFS_FAIL_CLR);

    // Handshake and latched status.
    assign ADDR_ACCEPTED_N_OUT = ~s_r.accept;
    assign DATA_CONFIRM_N_OUT  = ~((done_pt & is_acc) | s_r.xconf);
    assign LATCHED_READ_OUT    = s_r.rd;
    assign LATCHED_WORD_OUT    = s_r.word;

    // Bank addressing; refresh overrides the low odd-bank lines.
    assign EVEN_BANK_WORD_ADDR_OUT = even_full[15:1];
    assign ODD_BANK_WORD_ADDR_OUT  = is_rfsh ? {odd_word[14:7], s_r.rcnt[7:1]} : odd_word;
    assign BYTE_LANE_SELECT_OUT    = is_rfsh ? s_r.rcnt[0] : lane;
    assign ADDR_INCREMENT_CTL_OUT  = s_r.inc;
    assign EXTERNAL_ADDR_OUT       = even_full;
    assign REFRESH_LATE_STROBE_OUT    = s_r.late;
    assign REFRESH_EARLY_STROBE_N_OUT = ~rfsh_on;

    // Dynamic RAM: row half first, column half from the second stage on.
    assign ODD_RAM_ADDR_OUT  = (col_phase & is_acc) ? ODD_BANK_WORD_ADDR_OUT[13:7] :
                               ODD_BANK_WORD_ADDR_OUT[6:0];
    assign EVEN_RAM_ADDR_OUT = (col_phase & is_acc) ? EVEN_BANK_WORD_ADDR_OUT[13:7] :
                               EVEN_BANK_WORD_ADDR_OUT[6:0];
    assign COLUMN_STROBE_CLK_OUT = acc_on & ram_acc & s_r.chain[CHAIN_LEN-1];

    // Row strobes per section {odd high, odd low, even high, even low}.
    assign RAS_N_OUT[0] = ~(rfsh_on | (acc_on & ram_acc & even_en & ~even_full[15]));
    assign RAS_N_OUT[1] = ~(rfsh_on | (acc_on & ram_acc & even_en & even_full[15]));
    assign RAS_N_OUT[2] = ~(rfsh_on | (acc_on & ram_acc & odd_en & ~s_r.addr[15]));
    assign RAS_N_OUT[3] = ~(rfsh_on | (acc_on & ram_acc & odd_en & s_r.addr[15]));
    assign RAM_WRITE_OUT     = is_acc & ram_acc & ~s_r.rd;
    assign ODD_ARRAY_EN_OUT  = is_acc & ram_acc & odd_en;
    assign EVEN_ARRAY_EN_OUT = is_acc & ram_acc & even_en;
    assign ODD_RAM_DOUT_OUT  = s_r.odout;
    assign EVEN_RAM_DOUT_OUT = s_r.edout;
    assign ODD_PARITY_ERR_OUT  = s_r.ope;
    assign EVEN_PARITY_ERR_OUT = s_r.epe;
    assign HW_FAIL_IRQ_N_OUT   = ~s_r.hwfail;
    assign ERROR_LED_OUT       = s_r.hwfail;

    // ROM decode; firmware slot three is left to the extra EPROMs.
    assign ROM_STROBE_N_OUT       = ~(acc_on & rom_acc);
    assign CONSTANT_ROM_SEL_N_OUT = ~(acc_on & const_acc);
    assign odd_dev    = const_acc ? 2'h3 : odd_word[14:13];
    assign even_dev   = const_acc ? 2'h3 : even_full[15:14];
    assign rom_dec_en = ~ROM_STROBE_N_OUT & (~s_r.ram_sp | const_acc);
    assign ODD_ROM_CS_N_OUT  = (rom_dec_en & odd_en & (const_acc | odd_dev != 2'h3)) ?
                               ~(4'h1 << odd_dev) : 4'hF;
    assign EVEN_ROM_CS_N_OUT = (rom_dec_en & even_en & (const_acc | even_dev != 2'h3)) ?
                               ~(4'h1 << even_dev) : 4'hF;
    assign EXTRA_EPROM_EN_OUT = s_r.bank;

    // External request holds for the whole external access.
    assign EXTERNAL_SELECT_N_OUT = ~(s_r.seq == mas_pkg::MAS_EXTERN);
    assign EXT_REQUEST_N_OUT     = ~(s_r.seq == mas_pkg::MAS_EXTERN);

    // Checks on the sequencer's own outputs.
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);

    a_refresh_all_ras: assert property (rfsh_on |-> RAS_N_OUT == 4'h0)
        else $error("refresh did not strobe all sections");
    a_no_cas_refresh: assert property (!REFRESH_EARLY_STROBE_N_OUT |-> !COLUMN_STROBE_CLK_OUT)
        else $error("column strobe during refresh");
    a_byte_same_addr: assert property (is_acc && !s_r.word |->
        EVEN_BANK_WORD_ADDR_OUT == ODD_BANK_WORD_ADDR_OUT)
        else $error("byte access bank addresses differ");
    a_odd_word_inc: assert property (is_acc && s_r.word && lane |->
        EVEN_BANK_WORD_ADDR_OUT == 15'(ODD_BANK_WORD_ADDR_OUT + 15'h0001))
        else $error("odd word even address not incremented");
    a_ext_ram_window: assert property ($rose(!EXTERNAL_SELECT_N_OUT) && s_r.ram_sp |->
        s_r.addr[15:8] == 8'hFF)
        else $error("external RAM select outside window");
    a_ext_rom_window: assert property ($rose(!EXTERNAL_SELECT_N_OUT) && !s_r.ram_sp |->
        s_r.addr[15:14] == 2'h0 && !s_r.bank)
        else $error("external ROM select outside window or blocked");
    a_two_acks: assert property (!EXT_REQUEST_N_OUT && s_r.word && !s_r.inc && ack_fall |=>
        !EXT_REQUEST_N_OUT && ADDR_INCREMENT_CTL_OUT)
        else $error("word external request dropped after one acknowledge");
    a_accept_pulse: assert property ($fell(ADDR_ACCEPTED_N_OUT) |=> ADDR_ACCEPTED_N_OUT)
        else $error("accept strobe longer than one cycle");
    a_fail_latched: assert property (fail_set |=> !HW_FAIL_IRQ_N_OUT[*2])
        else $error("parity failure not latched");
    a_refresh_count: assert property (REFRESH_LATE_STROBE_OUT |=>
        s_r.rcnt == 8'($past(s_r.rcnt) + 8'h01))
        else $error("refresh row counter did not advance");
    a_confirm_access: assert property ($fell(ADDR_ACCEPTED_N_OUT) && is_acc |->
        ##[1:20] !DATA_CONFIRM_N_OUT)
        else $error("no data confirm after internal access");

    c_refresh: cover property (rfsh_on ##[1:20] REFRESH_LATE_STROBE_OUT);
    c_ext_word: cover property (s_r.inc && !EXT_REQUEST_N_OUT ##[1:50] s_r.xconf);
    c_parity_fail: cover property (fail_set);

endmodule : mas_sequencer

// file: test/mas_io_board.sv
// I/O board stand-in that answers external requests of the sequencer.
// Assumes one core clock and an active-high asynchronous reset.
`timescale 1ns/1ns
module mas_io_board #(
    parameter int DLY = 3
) (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       req_n_in,
    output logic            ack_n_out,
    output logic [7:0]      acks_out
);
    logic [3:0] wait_r;
    // One spaced pulse per byte while the request is held, so each is a new edge.
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in) {ack_n_out, acks_out, wait_r} <= {1'b1, 8'h00, 4'h0};
        else if (req_n_in) {ack_n_out, wait_r} <= {1'b1, 4'h0};
        else if (wait_r == DLY) {ack_n_out, acks_out, wait_r} <= {1'b0, acks_out + 8'h01, 4'h0};
        else {ack_n_out, wait_r} <= {1'b1, wait_r + 4'h1};
    end
endmodule : mas_io_board

// file: test/mas_sequencer_tb.sv
// Bench for the sequencer: registers, bank addressing, external space, parity, refresh.
// Assumes the I/O board stand-in answers every external request.
`timescale 1ns/1ns
module mas_sequencer_tb;
    logic CORE_CLK_IN = 0, RST_IN = 1, PSEL_IN = 0, PENABLE_IN = 0, PWRITE_IN = 0, serr;
    logic ADDR_VALID_N_IN = 1, INDIRECT_REQUEST_N_IN = 1, REFRESH_REQ_IN = 0, REQ_READ_IN = 1;
    logic REQ_WORD_IN = 0, RAM_SPACE_SEL_IN = 1, EXT_DATA_ACK_N_IN, PREADY_OUT, PSLVERR_OUT;
    logic ADDR_ACCEPTED_N_OUT, DATA_CONFIRM_N_OUT, LATCHED_READ_OUT, LATCHED_WORD_OUT;
    logic BYTE_LANE_SELECT_OUT, ADDR_INCREMENT_CTL_OUT, REFRESH_LATE_STROBE_OUT, RAM_WRITE_OUT;
    logic REFRESH_EARLY_STROBE_N_OUT, COLUMN_STROBE_CLK_OUT, ODD_ARRAY_EN_OUT, EVEN_ARRAY_EN_OUT;
    logic ODD_PARITY_ERR_OUT, EVEN_PARITY_ERR_OUT, HW_FAIL_IRQ_N_OUT, ERROR_LED_OUT;
    logic ROM_STROBE_N_OUT, CONSTANT_ROM_SEL_N_OUT, EXTRA_EPROM_EN_OUT, EXTERNAL_SELECT_N_OUT;
    logic        EXT_REQUEST_N_OUT;
    logic [11:0] PADDR_IN = 0;
    logic [31:0] PWDATA_IN = 0, PRDATA_OUT, rdat;
    logic [15:0] ADDR_IN = 0, EXTERNAL_ADDR_OUT;
    logic [14:0] EVEN_BANK_WORD_ADDR_OUT, ODD_BANK_WORD_ADDR_OUT;
    logic [8:0]  ODD_RAM_DIN_IN = 9'h05A, EVEN_RAM_DIN_IN = 9'h1C1;
    logic [8:0]  ODD_RAM_DOUT_OUT, EVEN_RAM_DOUT_OUT;
    logic [7:0]  ODD_WDATA_IN = 8'hA4, EVEN_WDATA_IN = 8'h3C, acks;
    logic [6:0]  ODD_RAM_ADDR_OUT, EVEN_RAM_ADDR_OUT;
    logic [3:0]  RAS_N_OUT, ODD_ROM_CS_N_OUT, EVEN_ROM_CS_N_OUT;
    logic [30:0] q[$];
    int          n_errors = 0, samples_checked = 0, cyc = 0, i, j, seed = 32'hCEF98295;
    mas_sequencer u_dut (.*);
    mas_io_board u_io (.clk_in(CORE_CLK_IN), .rst_in(RST_IN), .req_n_in(EXT_REQUEST_N_OUT),
                       .ack_n_out(EXT_DATA_ACK_N_IN), .acks_out(acks));
    always #5 CORE_CLK_IN = ~CORE_CLK_IN;
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("FAIL %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    // APB master: request held until pready is seen high with psel and penable.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CORE_CLK_IN);
        {PSEL_IN, PENABLE_IN, PWRITE_IN, PADDR_IN, PWDATA_IN} <= {2'b10, w, a, d};
        @(posedge CORE_CLK_IN);
        PENABLE_IN <= 1;
        do @(posedge CORE_CLK_IN); while (PREADY_OUT !== 1);
        {rdat, serr} = {PRDATA_OUT, PSLVERR_OUT};
        {PSEL_IN, PENABLE_IN} <= 2'b00;
    endtask : apb
    // One memory request; x says whether the external space should answer it.
    task automatic req(input logic [15:0] a, input logic w, r, rd, x);
        int t = 0;
        logic [7:0] k = acks;
        q.push_back({~x, (w & a[0]) ? a[15:1] + 15'h1 : a[15:1], a[15:1]});
        @(posedge CORE_CLK_IN);
        {ADDR_IN, REQ_WORD_IN, RAM_SPACE_SEL_IN, REQ_READ_IN, ADDR_VALID_N_IN} <= {a, w, r, rd, 1'b0};
        do @(posedge CORE_CLK_IN); while (ADDR_ACCEPTED_N_OUT !== 0 && ++t < 50);
        ADDR_VALID_N_IN <= 1;
        // Latched status and array controls while the access has just begun.
        chk("latch", {rd, w, (r & ~x) ? {~rd, w | a[0], w | ~a[0]} : 3'b000},
            {LATCHED_READ_OUT, LATCHED_WORD_OUT, RAM_WRITE_OUT, ODD_ARRAY_EN_OUT,
            EVEN_ARRAY_EN_OUT});
        if (x & w)
        begin
            do @(posedge CORE_CLK_IN); while (ADDR_INCREMENT_CTL_OUT !== 1 && ++t < 50);
            chk("ext_addr", a + 16'h1, EXTERNAL_ADDR_OUT);
        end
        do @(posedge CORE_CLK_IN); while (DATA_CONFIRM_N_OUT !== 0 && ++t < 80);
        chk("confirm", 0, DATA_CONFIRM_N_OUT);
        // At the confirm cycle the chain is full: column half, strobe of the space in use.
        if (!x) chk("strobes", {r, r, a[14:8]}, {ROM_STROBE_N_OUT, COLUMN_STROBE_CLK_OUT,
            ODD_RAM_ADDR_OUT});
        if (x) chk("acks", w ? 2 : 1, acks - k);
        repeat (12) @(posedge CORE_CLK_IN);
        $display("done request %h", a);
    endtask : req
    // A run this long means some wait never ended.
    always @(posedge CORE_CLK_IN)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors++;
            test_done();
        end
    end
    // Each accept pulse retires the oldest bank addressing note.
    always @(posedge CORE_CLK_IN)
        if (ADDR_ACCEPTED_N_OUT === 1'b0 && q.size() > 0)
            chk("banks", q.pop_front(), {EXTERNAL_SELECT_N_OUT, EVEN_BANK_WORD_ADDR_OUT,
                ODD_BANK_WORD_ADDR_OUT});
    initial
    begin
        repeat (4) @(posedge CORE_CLK_IN);
        RST_IN <= 0;
        apb(1, 12'h000, 32'h40);
        apb(0, 12'h004, 0);
        chk("bank", 1, {rdat[8], EXTRA_EPROM_EN_OUT} == 2'b11);
        apb(0, 12'h00C, 0);
        chk("slverr", 1, serr);
        req(16'h1000, 0, 0, 1, 0);
        apb(1, 12'h000, 0);
        req(16'h1001, 0, 0, 1, 1);
        req(16'h3FFF, 0, 0, 1, 1);
        req(16'h4000, 0, 0, 1, 0);
        req(16'hFEFF, 0, 1, 1, 0);
        req(16'hFF10, 1, 1, 1, 1);
        for (i = 0; i < 6; i++)
        begin
            rdat = $random(seed);
            req(16'h4000 + rdat[15:0] % 16'hBEFE, rdat[16], 1, 1, 0);
        end
        // The odd byte has an odd count of ones, so its ninth bit must be set.
        req(16'h5001, 1, 1, 0, 0);
        chk("dout", {9'h1A4, 9'h03C}, {ODD_RAM_DOUT_OUT, EVEN_RAM_DOUT_OUT});
        EVEN_RAM_DIN_IN <= 9'h0C1;
        req(16'h6000, 1, 1, 1, 0);
        chk("perr", 2'b01, {ODD_PARITY_ERR_OUT, EVEN_PARITY_ERR_OUT});
        chk("fail", 2'b01, {HW_FAIL_IRQ_N_OUT, ERROR_LED_OUT});
        EVEN_RAM_DIN_IN <= 9'h1C1;
        apb(1, 12'h008, 1);
        @(posedge CORE_CLK_IN);
        chk("fail_clr", 1, HW_FAIL_IRQ_N_OUT);
        // Two refreshes: the row counter must have stepped by one between them.
        for (j = 0; j < 2; j++)
        begin
            REFRESH_REQ_IN <= 1;
            i = 0;
            do @(posedge CORE_CLK_IN); while (REFRESH_EARLY_STROBE_N_OUT !== 0 && ++i < 50);
            chk("refresh", {5'h00, 8'(j)}, {RAS_N_OUT, COLUMN_STROBE_CLK_OUT,
                ODD_BANK_WORD_ADDR_OUT[6:0], BYTE_LANE_SELECT_OUT});
            REFRESH_REQ_IN <= 0;
            repeat (20) @(posedge CORE_CLK_IN);
            $display("done refresh %0d", j);
        end
        test_done();
    end
endmodule : mas_sequencer_tb
